/* common/fault_monitor_pkg.sv */
// constants and register map of the interface fault and alarm monitor
// Notes on behaviour
// R1: data-fault mode flags stuck tx data as fault
// R2: AIS mode flags all-ones tx data as alarm
// R3: check set to none keeps tx indication off
// R4: AIS never requests redundancy switching
// R5: tx PLL unlocked raises tx PLL fault
// R6: tx clock idle: alarm, use internal clock
// R7: unapplicable tx parameter raises configuration fault
// R8: read of empty rx buffer raises underflow
// R9: write into full rx buffer raises overflow
// R10: data-fault mode flags stuck rx data as fault
// R11: AIS mode flags all-ones rx data as alarm
// R12: check set to none keeps rx indication off
// R13: frame error rate above 1e-3 is a fault
// R14: buffer PLL unlocked raises buffer PLL fault
// R15: rx clock idle: fault, use satellite clock
// R16: demultiplexer not frame locked is a fault
// R17: fill below 10% or above 90% alarms
// R18: faults request switching, alarms never do
// R19: clock idle after window without edges
// R20: pattern must persist; first transition clears it
package fault_monitor_pkg;
    localparam logic [11:0] ctrl_addr = 12'h000;
    localparam logic [11:0] status_addr = 12'h004;
    localparam logic [11:0] sticky_addr = 12'h008;
    localparam logic [11:0] fill_addr = 12'h00C;
    localparam logic [11:0] errors_addr = 12'h010;
    // ctrl fields: tx check mode [1:0], rx check mode [3:2]
    localparam int ctrl_tx_mode_lsb = 0;
    localparam int ctrl_rx_mode_lsb = 2;
    localparam logic [31:0] ctrl_reset = 32'h0000_0000;
    typedef enum logic [1:0]
    {
        check_none = 2'b00,
        check_data = 2'b01,
        check_ais = 2'b10
    } check_mode_t;
    // status bit positions
    localparam int st_tx_stable = 0;
    localparam int st_tx_ais = 1;
    localparam int st_tx_pll = 2;
    localparam int st_tx_clk = 3;
    localparam int st_tx_cfg = 4;
    localparam int st_underflow = 5;
    localparam int st_overflow = 6;
    localparam int st_rx_stable = 7;
    localparam int st_rx_ais = 8;
    localparam int st_frame_error_rate_fault = 9;
    localparam int st_buf_pll = 10;
    localparam int st_rx_clk = 11;
    localparam int st_demux = 12;
    localparam int st_fill = 13;
    localparam int status_bits = 14;
    // timing: activity window and pattern persistence, in ns
    localparam int clk_period_ns = 4;
    localparam int activity_window_ns = 4000;
    localparam int persist_ns = 4000;
    localparam int activity_cycles = activity_window_ns / clk_period_ns;
    localparam int persist_cycles = persist_ns / clk_period_ns;
    // frame error ratio threshold: 1 in 1000
    localparam int ber_denominator = 1000;
    localparam int fill_low_pct = 10;
    localparam int fill_high_pct = 90;
    localparam logic [1:0] resp_okay = 2'b00;
    localparam logic [1:0] resp_slverr = 2'b10;
endpackage

/* rtl/interface_fault_alarm_monitor.sv */
// interface fault and alarm monitor with an AXI4-Lite register slave
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module interface_fault_alarm_monitor #(
    parameter int fill_width = 16,
    parameter int activity_count = fault_monitor_pkg::activity_cycles,
    parameter int persist_count = fault_monitor_pkg::persist_cycles
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic tx_data,
    input wire logic tx_data_valid,
    input wire logic rx_data,
    input wire logic rx_data_valid,
    input wire logic tx_pll_locked,
    input wire logic buf_pll_locked,
    input wire logic tx_if_clk,
    input wire logic rx_if_clk,
    input wire logic tx_cfg_reject,
    input wire logic buf_read,
    input wire logic buf_write,
    input wire logic buf_empty,
    input wire logic buf_full,
    input wire logic [fill_width-1:0] buf_fill,
    input wire logic [fill_width-1:0] buf_depth,
    input wire logic frame_bit,
    input wire logic frame_bit_error,
    input wire logic demux_locked,
    output logic tx_stuck_data_indication,
    output logic rx_stuck_data_indication,
    output logic frame_error_rate_fault,
    output logic rx_clock_activity_loss,
    output logic demultiplexer_sync_loss,
    output logic tx_clock_activity_loss,
    output logic tx_use_internal_clock,
    output logic rx_use_satellite_clock,
    output logic [fault_monitor_pkg::status_bits-1:0] status,
    output logic switch_request
);
    initial
    begin
        if (fill_width < 8 || fill_width > 32 || activity_count < 2 || persist_count < 2)
            $error("interface_fault_alarm_monitor: unsupported parameter value");
    end

    localparam int cw = 32;

    logic [31:0] ctrl;
    logic [fault_monitor_pkg::status_bits-1:0] sticky;
    logic [15:0] ber_bits;
    logic [15:0] ber_errs;

    logic [cw-1:0] tx_run;
    logic [cw-1:0] rx_run;
    logic tx_prev;
    logic rx_prev;
    logic tx_ones;
    logic rx_ones;

    logic [cw-1:0] tx_idle;
    logic [cw-1:0] rx_idle;
    logic tx_clk_d;
    logic rx_clk_d;

    logic aw_held;
    logic w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [31:0] w_mask;

    wire fault_monitor_pkg::check_mode_t tx_mode =
        fault_monitor_pkg::check_mode_t'(ctrl[fault_monitor_pkg::ctrl_tx_mode_lsb +: 2]);
    wire fault_monitor_pkg::check_mode_t rx_mode =
        fault_monitor_pkg::check_mode_t'(ctrl[fault_monitor_pkg::ctrl_rx_mode_lsb +: 2]);

    // a run counter saturates so a long stuck line cannot wrap back to clear
    function automatic logic [cw-1:0] run_next(input logic [cw-1:0] run, input logic valid,
        input logic bit_now, input logic bit_prev);
        if (!valid)
            run_next = run;
        else if (bit_now != bit_prev)
            run_next = '0;
        else if (run == {cw{1'b1}})
            run_next = run;
        else
            run_next = run + 1'b1;
    endfunction

    function automatic logic [cw-1:0] idle_next(input logic [cw-1:0] idle, input logic edge_seen);
        if (edge_seen)
            idle_next = '0;
        else if (idle == {cw{1'b1}})
            idle_next = idle;
        else
            idle_next = idle + 1'b1;
    endfunction

    wire [cw-1:0] next_tx_run = run_next(tx_run, tx_data_valid, tx_data, tx_prev);
    wire [cw-1:0] next_rx_run = run_next(rx_run, rx_data_valid, rx_data, rx_prev);
    wire [cw-1:0] next_tx_idle = idle_next(tx_idle, tx_if_clk != tx_clk_d);
    wire [cw-1:0] next_rx_idle = idle_next(rx_idle, rx_if_clk != rx_clk_d);

    // pattern must hold for the persistence interval; a transition resets the run [R20]
    wire tx_persist = tx_run >= cw'(persist_count);
    wire rx_persist = rx_run >= cw'(persist_count);
    wire tx_stable = tx_persist && (tx_mode == fault_monitor_pkg::check_data); // [R1] [R3]
    wire tx_ais = tx_persist && tx_ones && (tx_mode == fault_monitor_pkg::check_ais); // [R2] [R3]
    wire rx_stable = rx_persist && (rx_mode == fault_monitor_pkg::check_data); // [R10] [R12]
    wire rx_ais = rx_persist && rx_ones &&
        (rx_mode == fault_monitor_pkg::check_ais); // [R11] [R12]
    wire tx_clk_dead = tx_idle >= cw'(activity_count); // [R19]
    wire rx_clk_dead = rx_idle >= cw'(activity_count); // [R19]

    // 1e-3 judged per block of 1000 frame bits: more than one error per block
    wire ber_block_end = frame_bit && (ber_bits == 16'(fault_monitor_pkg::ber_denominator - 1));
    wire [15:0] ber_errs_now = ber_errs + 16'(frame_bit && frame_bit_error);

    wire [fill_width+6:0] fill_pct = (fill_width + 7)'(buf_fill) * 7'd100;
    wire [fill_width+6:0] depth_lo =
        (fill_width + 7)'(buf_depth) * 7'(fault_monitor_pkg::fill_low_pct);
    wire [fill_width+6:0] depth_hi =
        (fill_width + 7)'(buf_depth) * 7'(fault_monitor_pkg::fill_high_pct);
    wire fill_bad = (fill_pct < depth_lo) || (fill_pct > depth_hi); // [R17]
    wire underflow = buf_read && buf_empty; // [R8]
    wire overflow = buf_write && buf_full; // [R9]

    logic [fault_monitor_pkg::status_bits-1:0] next_status;
    always_comb
    begin
        next_status = '0;

        next_status[fault_monitor_pkg::st_tx_stable] = tx_stable;
        next_status[fault_monitor_pkg::st_tx_ais] = tx_ais;
        next_status[fault_monitor_pkg::st_tx_pll] = !tx_pll_locked; // [R5]
        next_status[fault_monitor_pkg::st_tx_clk] = tx_clk_dead; // [R6]
        next_status[fault_monitor_pkg::st_tx_cfg] = tx_cfg_reject; // [R7]

        next_status[fault_monitor_pkg::st_underflow] = underflow;
        next_status[fault_monitor_pkg::st_overflow] = overflow;

        next_status[fault_monitor_pkg::st_rx_stable] = rx_stable;
        next_status[fault_monitor_pkg::st_rx_ais] = rx_ais;
        next_status[fault_monitor_pkg::st_frame_error_rate_fault] = frame_error_rate_fault;
        next_status[fault_monitor_pkg::st_buf_pll] = !buf_pll_locked; // [R14]
        next_status[fault_monitor_pkg::st_rx_clk] = rx_clk_dead; // [R15]
        next_status[fault_monitor_pkg::st_demux] = !demux_locked; // [R16]
        next_status[fault_monitor_pkg::st_fill] = fill_bad;
    end

    // only faults switch; AIS, tx clock activity, buffer and fill alarms do not [R4] [R18]
    wire next_switch = tx_stable || !tx_pll_locked || tx_cfg_reject || rx_stable ||
        frame_error_rate_fault || !buf_pll_locked || rx_clk_dead || !demux_locked;

    wire [fault_monitor_pkg::status_bits-1:0] pad = '0;
    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire do_read = s_axi_arvalid && s_axi_arready;
    wire wr_ctrl = do_write && (aw_addr == fault_monitor_pkg::ctrl_addr);
    wire wr_sticky = do_write && (aw_addr == fault_monitor_pkg::sticky_addr);
    wire wr_known = wr_ctrl || wr_sticky;
    wire [31:0] strb_mask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
        {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    wire [fault_monitor_pkg::status_bits-1:0] clr_bits =
        wr_sticky ? w_data[fault_monitor_pkg::status_bits-1:0] : pad;
    // set wins over a simultaneous write-one-to-clear
    wire [fault_monitor_pkg::status_bits-1:0] next_sticky = (sticky & ~clr_bits) | next_status;
    wire rd_known = (s_axi_araddr == fault_monitor_pkg::ctrl_addr) ||
        (s_axi_araddr == fault_monitor_pkg::status_addr) ||
        (s_axi_araddr == fault_monitor_pkg::sticky_addr) ||
        (s_axi_araddr == fault_monitor_pkg::fill_addr) ||
        (s_axi_araddr == fault_monitor_pkg::errors_addr);
    wire [31:0] rd_value =
        (s_axi_araddr == fault_monitor_pkg::ctrl_addr) ? ctrl :
        (s_axi_araddr == fault_monitor_pkg::status_addr) ? 32'(status) :
        (s_axi_araddr == fault_monitor_pkg::sticky_addr) ? 32'(sticky) :
        (s_axi_araddr == fault_monitor_pkg::fill_addr) ? 32'(buf_fill) :
        (s_axi_araddr == fault_monitor_pkg::errors_addr) ? {ber_bits, ber_errs} : 32'h0000_0000;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tx_run <= '0;
            rx_run <= '0;
            tx_prev <= 1'b0;
            rx_prev <= 1'b0;
            tx_ones <= 1'b0;
            rx_ones <= 1'b0;
            tx_idle <= '0;
            rx_idle <= '0;
            tx_clk_d <= 1'b0;
            rx_clk_d <= 1'b0;
        end
        else if (clk_en)
        begin
            tx_run <= next_tx_run;
            rx_run <= next_rx_run;
            if (tx_data_valid)
            begin
                tx_prev <= tx_data;
                tx_ones <= tx_data;
            end
            if (rx_data_valid)
            begin
                rx_prev <= rx_data;
                rx_ones <= rx_data;
            end
            tx_idle <= next_tx_idle;
            rx_idle <= next_rx_idle;
            tx_clk_d <= tx_if_clk;
            rx_clk_d <= rx_if_clk;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ber_bits <= 16'h0000;
            ber_errs <= 16'h0000;
            frame_error_rate_fault <= 1'b0;
        end
        else if (clk_en && frame_bit)
        begin
            ber_bits <= ber_block_end ? 16'h0000 : ber_bits + 16'h0001;
            ber_errs <= ber_block_end ? 16'h0000 : ber_errs_now;
            if (ber_block_end)
                frame_error_rate_fault <= ber_errs_now > 16'h0001; // [R13]
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            status <= '0;
            sticky <= '0;
            switch_request <= 1'b0;
            tx_stuck_data_indication <= 1'b0;
            rx_stuck_data_indication <= 1'b0;
            rx_clock_activity_loss <= 1'b0;
            demultiplexer_sync_loss <= 1'b0;
            tx_clock_activity_loss <= 1'b0;
            tx_use_internal_clock <= 1'b0;
            rx_use_satellite_clock <= 1'b0;
        end
        else if (clk_en)
        begin
            status <= next_status;
            sticky <= next_sticky;
            switch_request <= next_switch; // [R18]
            tx_stuck_data_indication <= tx_stable || tx_ais;
            rx_stuck_data_indication <= rx_stable || rx_ais;
            rx_clock_activity_loss <= rx_clk_dead;
            demultiplexer_sync_loss <= !demux_locked; // [R16]
            tx_clock_activity_loss <= tx_clk_dead;
            tx_use_internal_clock <= tx_clk_dead; // [R6]
            rx_use_satellite_clock <= rx_clk_dead; // [R15]
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl <= fault_monitor_pkg::ctrl_reset;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h0000_0000;
            w_mask <= 32'h0000_0000;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= fault_monitor_pkg::resp_okay;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= fault_monitor_pkg::resp_okay;
        end
        else if (clk_en)
        begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;

            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata & strb_mask;
                w_mask <= strb_mask;
            end

            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? fault_monitor_pkg::resp_okay :
                    fault_monitor_pkg::resp_slverr;
                if (wr_ctrl)
                    ctrl <= (ctrl & ~w_mask) | w_data;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;

            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (do_read)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_value;
                s_axi_rresp <= rd_known ? fault_monitor_pkg::resp_okay :
                    fault_monitor_pkg::resp_slverr;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule // interface_fault_alarm_monitor
`default_nettype wire

/* bench/interface_fault_alarm_monitor_properties.sv */
// port-level assertions for the interface fault and alarm monitor
`timescale 1ns/10ps
`default_nettype none
module interface_fault_alarm_monitor_properties #(
    parameter int fill_width = 16,
    parameter int activity_count = 8
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tx_pll_locked,
    input wire logic buf_pll_locked,
    input wire logic tx_cfg_reject,
    input wire logic buf_read,
    input wire logic buf_write,
    input wire logic buf_empty,
    input wire logic buf_full,
    input wire logic [fill_width-1:0] buf_fill,
    input wire logic [fill_width-1:0] buf_depth,
    input wire logic demux_locked,
    input wire logic rx_if_clk,
    input wire logic demultiplexer_sync_loss,
    input wire logic tx_clock_activity_loss,
    input wire logic tx_use_internal_clock,
    input wire logic rx_clock_activity_loss,
    input wire logic rx_use_satellite_clock,
    input wire logic [fault_monitor_pkg::status_bits-1:0] status,
    input wire logic switch_request
);
    // fault bits; the rest only alarm
    localparam logic [13:0] fault_mask = 14'h1E95;
    logic rx_clk_q;
    int unsigned idle_cnt;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rx_clk_q <= 1'b0;
            idle_cnt <= 0;
        end
        else
        begin
            rx_clk_q <= rx_if_clk;
            idle_cnt <= (rx_if_clk != rx_clk_q) ? 0 : idle_cnt + 1;
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    tx_pll_fault_a: assert property (!tx_pll_locked [*3] |-> status[2])
        else $error("tx pll unlock not reported");
    cfg_fault_a: assert property (tx_cfg_reject [*3] |-> status[4])
        else $error("tx configuration fault missing");
    buf_pll_fault_a: assert property (!buf_pll_locked [*3] |-> status[10])
        else $error("buffer pll unlock not reported");
    demux_fault_a: assert property (!demux_locked [*3] |-> demultiplexer_sync_loss)
        else $error("demultiplexer lock loss missing");
    underflow_seen_a: assert property (buf_read && buf_empty |-> ##[1:2] status[5])
        else $error("underflow not flagged");
    overflow_seen_a: assert property (buf_write && buf_full |-> ##[1:2] status[6])
        else $error("overflow not flagged");
    tx_fallback_a: assert property (tx_clock_activity_loss
        |-> ##[0:1] tx_use_internal_clock)
        else $error("tx timing did not fall back");
    rx_fallback_a: assert property (rx_clock_activity_loss
        |-> ##[0:1] rx_use_satellite_clock)
        else $error("rx timing did not fall back");
    rx_idle_a: assert property (idle_cnt > activity_count + 3 |-> rx_clock_activity_loss)
        else $error("idle rx clock not detected");
    alarm_no_switch_a: assert property (((status & fault_mask) == 14'h0) [*3]
        |-> !switch_request)
        else $error("switch requested without a fault");
    fault_switch_a: assert property ((|(status & fault_mask)) [*3] |-> switch_request)
        else $error("fault did not request switching");
    fill_alarm_a: assert property ((32'(buf_fill) * 100 < 32'(buf_depth) * 10
        || 32'(buf_fill) * 100 > 32'(buf_depth) * 90) [*3] |-> status[13])
        else $error("fill alarm missing");
endmodule // interface_fault_alarm_monitor_properties
bind interface_fault_alarm_monitor interface_fault_alarm_monitor_properties #(
    .fill_width(fill_width),
    .activity_count(activity_count)
) i_interface_fault_alarm_monitor_properties (.*);
`default_nettype wire

/* bench/far_side_model.sv */
// terrestrial equipment and satellite path: serial data and interface clocks
`timescale 1ns/10ps
`default_nettype none
module far_side_model
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tx_clk_run,
    input wire logic rx_clk_run,
    input wire logic [1:0] tx_pat,
    input wire logic [1:0] rx_pat,
    output logic tx_data,
    output logic tx_data_valid,
    output logic rx_data,
    output logic rx_data_valid,
    output logic tx_if_clk,
    output logic rx_if_clk
);
    // pattern 0 alternates, 1 all ones, 2 all zeros; a bit every other cycle
    logic [1:0] ph;
    logic alt;
    wire logic tx_bit = (tx_pat == 2'h1) | ((tx_pat == 2'h0) & alt);
    wire logic rx_bit = (rx_pat == 2'h1) | ((rx_pat == 2'h0) & alt);
    always_ff @(posedge aclk)
    begin
        ph <= aresetn ? ph + 2'h1 : 2'h0;
        alt <= aresetn && (ph[0] ? ~alt : alt);
        tx_data_valid <= ph[0];
        rx_data_valid <= ph[0];
        // inverse of the current bit between strobes; in pattern 0 that repeats the last strobed bit
        tx_data <= ph[0] ? tx_bit : ~tx_bit;
        rx_data <= ph[0] ? rx_bit : ~rx_bit;
        tx_if_clk <= tx_clk_run ? ph[1] : tx_if_clk;
        rx_if_clk <= rx_clk_run ? ~ph[1] : rx_if_clk;
    end
endmodule // far_side_model
`default_nettype wire

/* bench/interface_fault_alarm_monitor_tb_top.sv */
// self-checking bench for the interface fault and alarm monitor
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((e) !== (g)) begin bad_count++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module interface_fault_alarm_monitor_tb_top;
    typedef struct {logic [1:0] r; logic [31:0] d, m;} note_t;
    note_t bq[$], rq[$], nb, nr;
    int bad_count = 0, total_checks = 0, cycles = 0;
    localparam logic [11:0] sta = fault_monitor_pkg::status_addr;
    localparam logic [11:0] stk = fault_monitor_pkg::sticky_addr;
    logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, e, seed = 32'hC480;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, tx_pat = 2'h0, rx_pat = 2'h0;
    logic tx_data, tx_data_valid, rx_data, rx_data_valid, tx_if_clk, rx_if_clk;
    logic tx_clk_run = 1'b1, rx_clk_run = 1'b1, tx_pll_locked = 1'b1, buf_pll_locked = 1'b1;
    logic tx_cfg_reject = 1'b0, demux_locked = 1'b1, frame_bit = 1'b0, frame_bit_error = 1'b0;
    logic buf_read = 1'b0, buf_write = 1'b0, buf_empty = 1'b0, buf_full = 1'b0;
    logic [15:0] buf_fill = 16'h01F4, buf_depth = 16'h03E8;
    logic [3:0] sel;
    logic [fault_monitor_pkg::status_bits-1:0] status;
    logic tx_stuck_data_indication, rx_stuck_data_indication, frame_error_rate_fault;
    logic rx_clock_activity_loss, demultiplexer_sync_loss, tx_clock_activity_loss;
    logic tx_use_internal_clock, rx_use_satellite_clock, switch_request;
    int f;
    far_side_model i_far_side_model (.*);
    interface_fault_alarm_monitor #(.activity_count(8), .persist_count(8))
    i_interface_fault_alarm_monitor (.*);
    always #2 aclk = ~aclk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
        logic aw_d = 1'b0, w_d = 1'b0;
        bq.push_back('{r, 32'h0, 32'h0});
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_d && w_d))
        begin
            @(posedge aclk);
            aw_d = aw_d | s_axi_awready;
            w_d = w_d | s_axi_wready;
            s_axi_awvalid <= !aw_d;
            s_axi_wvalid <= !w_d;
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] d, m, input logic [1:0] r = 2'h0);
        rq.push_back('{r, d & m, m});
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask
    task automatic pulse(input logic em, input logic fu);
        @(posedge aclk);
        buf_read <= 1'b1;
        buf_write <= 1'b1;
        buf_empty <= em;
        buf_full <= fu;
        @(posedge aclk);
        buf_read <= 1'b0;
        buf_write <= 1'b0;
        buf_empty <= 1'b0;
        buf_full <= 1'b0;
    endtask
    task automatic frames(input int errs);
        for (int k = 0; k < 1001; k++)
        begin
            @(posedge aclk);
            frame_bit <= (k < 1000);
            frame_bit_error <= (k < errs);
        end
        repeat (4) @(posedge aclk);
    endtask
    always @(posedge aclk)
    begin
        if (s_axi_bvalid && s_axi_bready)
        begin
            nb = bq.pop_front();
            `CHK("bresp", nb.r, s_axi_bresp)
        end
        if (s_axi_rvalid && s_axi_rready)
        begin
            nr = rq.pop_front();
            `CHK("rresp", nr.r, s_axi_rresp)
            `CHK("rdata", nr.d, s_axi_rdata & nr.m)
        end
    end
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            bad_count++;
            print_verdict();
        end
    end
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(fault_monitor_pkg::ctrl_addr, 32'h0, 32'hFFFF_FFFF);
        rd(12'h020, 32'h0, 32'h0, fault_monitor_pkg::resp_slverr);
        wr(sta, 32'hFFFF_FFFF, fault_monitor_pkg::resp_slverr);
        rd(sta, 32'h0, 32'h3FFF);
        $display("test bus done");
        for (int m = 0; m < 4; m++)
            for (int p = 1; p < 3; p++)
            begin
                wr(fault_monitor_pkg::ctrl_addr, {28'h0, 2'(m), 2'(m)});
                tx_pat <= 2'(p);
                rx_pat <= 2'(p);
                repeat (4) @(posedge aclk);
                rd(sta, 32'h0, 32'h183);
                repeat (36) @(posedge aclk);
                e = ((m == 1) ? 32'h81 : 32'h0) | ((m == 2 && p == 1) ? 32'h102 : 32'h0);
                rd(sta, e, 32'h183);
                `CHK("tx ind", m == 1 || m == 2 && p == 1, tx_stuck_data_indication)
                `CHK("rx ind", m == 1 || m == 2 && p == 1, rx_stuck_data_indication)
                tx_pat <= 2'h0;
                rx_pat <= 2'h0;
                repeat (6) @(posedge aclk);
                rd(sta, 32'h0, 32'h183);
            end
        $display("test stuck data done");
        for (int i = 0; i < 5; i++)
        begin
            sel = 4'(1 << i);
            tx_pll_locked <= !sel[0];
            tx_cfg_reject <= sel[1];
            buf_pll_locked <= !sel[2];
            demux_locked <= !sel[3];
            repeat (4) @(posedge aclk);
            e = {19'h0, sel[3], 1'b0, sel[2], 5'h0, sel[1], 1'b0, sel[0], 2'h0};
            rd(sta, e, 32'h1414);
        end
        tx_clk_run <= 1'b0;
        rx_clk_run <= 1'b0;
        repeat (20) @(posedge aclk);
        rd(sta, 32'h808, 32'h808);
        tx_clk_run <= 1'b1;
        rx_clk_run <= 1'b1;
        repeat (12) @(posedge aclk);
        rd(sta, 32'h0, 32'h808);
        $display("test levels and clocks done");
        wr(stk, 32'hFFFF_FFFF);
        pulse(1'b0, 1'b0);
        rd(stk, 32'h0, 32'h60);
        pulse(1'b1, 1'b1);
        rd(stk, 32'h60, 32'h60);
        wr(stk, 32'h60);
        rd(stk, 32'h0, 32'h60);
        $display("test buffer events done");
        for (int i = 0; i < 10; i++)
        begin
            seed = lfsr(seed);
            f = (i == 0) ? 99 : (i == 1) ? 100 : (i == 2) ? 900 : (i == 3) ? 901 : seed % 1001;
            buf_fill <= 16'(f);
            repeat (4) @(posedge aclk);
            e = (f < 100 || f > 900) ? 32'h2000 : 32'h0;
            rd(sta, e, 32'h2000);
        end
        frames(2);
        rd(sta, 32'h200, 32'h200);
        `CHK("ber", 1'b1, frame_error_rate_fault)
        frames(1);
        rd(sta, 32'h0, 32'h200);
        $display("test fill and error rate done");
        repeat (4) @(posedge aclk);
        print_verdict();
    end
endmodule // interface_fault_alarm_monitor_tb_top
`default_nettype wire
